// [hw/std_timer_compare_pwm.sv]
`include "timer_cfg.svh"

module std_timer_compare_pwm
  import timer_pkg::*;
#(
  parameter int CW = `CW_DEFAULT,
  parameter int PW = `PW_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             timer_output_pin_o,
  output logic             timer_output_pin_oe
);

  generate
    // Compare A high byte lane writes bits CW-1:8, so the counter must be wider than a byte
    if (CW < 9 || CW > 16 || PW < 1 || PW >= CW) begin : g_bad_width
      $error("std_timer_compare_pwm: unsupported counter or period width");
    end
  endgenerate

  typedef struct packed {
    logic               counter_on;
    logic               pause;
    logic               on_prev;
    timer_ctrl1_t       ctrl1;
    logic [CW-1:0]      compare_a_value;
    logic [PW-1:0]      period_compare_value;
    logic [CW-1:0]      count;
    logic               match_a_flag;
    logic               match_p_flag;
    logic               level;
    logic               pin;
    logic               pin_oe;
    logic [31:0]        rdata;
    logic               ready;
    logic               slverr;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic               hit_a;
  logic               hit_p;
  logic               pwm_active;
  logic [CW-1:0]      p_target;
  logic               setup;
  logic               wr;
  logic               mapped;
  logic [31:0]        rd_mux;

  assign p_target = {s_q.period_compare_value, {(CW-PW){1'b0}}};

  match_unit #(
    .W      (CW)
  ) u_match_a (
    .count  (s_q.count),
    .target (s_q.compare_a_value),
    .hit    (hit_a)
  );

  // Zero period target wraps the counter through its maximum value
  match_unit #(
    .W      (CW)
  ) u_match_p (
    .count  (s_q.count),
    .target (p_target),
    .hit    (hit_p)
  );

  pwm_level #(
    .CW     (CW),
    .PW     (PW)
  ) u_pwm (
    .count  (s_q.count),
    .cmp_a  (s_q.compare_a_value),
    .cmp_p  (s_q.period_compare_value),
    .swap   (s_q.ctrl1.duty_period_swap),
    .active (pwm_active)
  );

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite & s_q.ready;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CTRL0_OFS: begin
        rd_mux[`CTRL0_PAUSE_BIT] = s_q.pause;
        rd_mux[`CTRL0_ON_BIT]    = s_q.counter_on;
      end
      `CTRL1_OFS: begin
        rd_mux[7:0] = s_q.ctrl1;
      end
      `CMPA_OFS: begin
        rd_mux[CW-1:0] = s_q.compare_a_value;
      end
      `CMPP_OFS: begin
        rd_mux[PW-1:0] = s_q.period_compare_value;
      end
      `STATUS_OFS: begin
        rd_mux[`STATUS_A_BIT] = s_q.match_a_flag;
        rd_mux[`STATUS_P_BIT] = s_q.match_p_flag;
      end
      `COUNT_OFS: begin
        rd_mux[CW-1:0] = s_q.count;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    logic on_rise;
    logic running;
    logic single_pulse;
    logic cmp_like;
    logic clear_hit;
    logic evt_a;
    logic evt_p;
    logic lvl;
    on_rise      = 1'b0;
    running      = 1'b0;
    single_pulse = 1'b0;
    cmp_like     = 1'b0;
    clear_hit    = 1'b0;
    evt_a        = 1'b0;
    evt_p        = 1'b0;
    lvl          = 1'b0;

    s_d = s_q;

    // Bus answers one cycle after setup, so the access phase is always one cycle
    s_d.ready  = setup;
    s_d.slverr = setup & ~mapped;
    s_d.rdata  = (setup & ~pwrite) ? rd_mux : 32'h0000_0000;

    on_rise      = s_q.counter_on & ~s_q.on_prev;
    running      = s_q.counter_on & s_q.on_prev & ~s_q.pause;
    single_pulse = (s_q.ctrl1.mode == MODE_PWM) & (s_q.ctrl1.pin_action == PIN_ACT_3);
    cmp_like     = (s_q.ctrl1.mode == MODE_COMPARE) | (s_q.ctrl1.mode == MODE_TIMER);

    case (s_q.ctrl1.mode)
      MODE_COMPARE, MODE_TIMER: begin
        evt_a     = running & hit_a;
        evt_p     = running & hit_p & ~s_q.ctrl1.clear_source_select;
        clear_hit = s_q.ctrl1.clear_source_select ? hit_a : hit_p;
      end
      MODE_PWM: begin
        if (single_pulse) begin
          evt_a     = running & hit_a;
          clear_hit = 1'b0;
        end else begin
          evt_a     = running & hit_a;
          evt_p     = running & hit_p;
          clear_hit = s_q.ctrl1.duty_period_swap ? hit_a : hit_p;
        end
      end
      MODE_CAPTURE: begin
        evt_p     = running & hit_p;
        clear_hit = hit_p;
      end
      default: begin
        clear_hit = 1'b0;
      end
    endcase

    s_d.on_prev = s_q.counter_on;
    if (on_rise) begin
      s_d.count = '0;
    end else if (running) begin
      if (single_pulse & hit_a) begin
        s_d.count = s_q.count;
      end else if (clear_hit) begin
        s_d.count = '0;
      end else begin
        s_d.count = s_q.count + {{(CW-1){1'b0}}, 1'b1};
      end
    end

    // Hardware stop in single pulse ends the pulse at the A match
    if (single_pulse & evt_a) begin
      s_d.counter_on = 1'b0;
    end

    if (wr & (paddr == `STATUS_OFS) & pstrb[0]) begin
      if (pwdata[`STATUS_A_BIT]) begin
        s_d.match_a_flag = 1'b0;
      end
      if (pwdata[`STATUS_P_BIT]) begin
        s_d.match_p_flag = 1'b0;
      end
    end
    // A match in the clearing cycle must not be lost
    if (evt_a) begin
      s_d.match_a_flag = 1'b1;
    end
    if (evt_p) begin
      s_d.match_p_flag = 1'b1;
    end

    lvl = s_q.level;
    case (s_q.ctrl1.mode)
      MODE_COMPARE: begin
        if (on_rise) begin
          lvl = s_q.ctrl1.output_level_ctrl;
        end else if (evt_a) begin
          case (s_q.ctrl1.pin_action)
            PIN_ACT_1: lvl = 1'b0;
            PIN_ACT_2: lvl = 1'b1;
            PIN_ACT_3: lvl = ~s_q.level;
            default:   lvl = s_q.level;
          endcase
        end
      end
      MODE_PWM: begin
        case (s_q.ctrl1.pin_action)
          PIN_ACT_0: lvl = ~s_q.ctrl1.output_level_ctrl;
          PIN_ACT_1: lvl = s_q.ctrl1.output_level_ctrl;
          PIN_ACT_2: lvl = s_q.ctrl1.output_level_ctrl ? pwm_active : ~pwm_active;
          PIN_ACT_3: lvl = s_d.counter_on ? s_q.ctrl1.output_level_ctrl
                                          : ~s_q.ctrl1.output_level_ctrl;
          default:   lvl = s_q.level;
        endcase
      end
      default: begin
        lvl = s_q.level;
      end
    endcase
    s_d.level = lvl;

    // Pin is released in timer and capture modes, so the output bits do nothing
    s_d.pin_oe = (s_q.ctrl1.mode == MODE_COMPARE) | (s_q.ctrl1.mode == MODE_PWM);
    s_d.pin    = s_d.pin_oe & (lvl ^ s_q.ctrl1.output_invert);

    // Software writes land last on control so a write of counter_on wins the stop
    if (wr & pstrb[0]) begin
      case (paddr)
        `CTRL0_OFS: begin
          s_d.pause      = pwdata[`CTRL0_PAUSE_BIT];
          s_d.counter_on = pwdata[`CTRL0_ON_BIT];
        end
        `CTRL1_OFS: begin
          s_d.ctrl1 = timer_ctrl1_t'(pwdata[7:0]);
        end
        `CMPA_OFS: begin
          s_d.compare_a_value[7:0] = pwdata[7:0];
        end
        `CMPP_OFS: begin
          s_d.period_compare_value = pwdata[PW-1:0];
        end
        default: begin
          s_d.pause = s_d.pause;
        end
      endcase
    end
    if (wr & pstrb[1] & (paddr == `CMPA_OFS)) begin
      s_d.compare_a_value[CW-1:8] = pwdata[CW-1:8];
    end

    if (cmp_like) begin
      s_d.level = s_d.level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.ctrl1 <= timer_ctrl1_t'(`CTRL1_RESET);
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata              = s_q.rdata;
  assign pready              = s_q.ready;
  assign pslverr             = s_q.slverr;
  assign timer_output_pin_o  = s_q.pin;
  assign timer_output_pin_oe = s_q.pin_oe;

endmodule

// [hw/timer_cfg.svh]
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define CTRL0_OFS        12'h000
`define CTRL1_OFS        12'h004
`define CMPA_OFS         12'h008
`define CMPP_OFS         12'h00C
`define STATUS_OFS       12'h010
`define COUNT_OFS        12'h014

`define CTRL0_PAUSE_BIT  7
`define CTRL0_ON_BIT     3
`define STATUS_A_BIT     0
`define STATUS_P_BIT     1

`define CTRL0_RESET      8'h00
`define CTRL1_RESET      8'h00

`define CW_DEFAULT       10
`define PW_DEFAULT       3

`endif

// [hw/timer_pkg.sv]
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } timer_mode_t;

  typedef enum logic [1:0] {
    PIN_ACT_0 = 2'b00,
    PIN_ACT_1 = 2'b01,
    PIN_ACT_2 = 2'b10,
    PIN_ACT_3 = 2'b11
  } pin_action_t;

  typedef struct packed {
    timer_mode_t mode;
    pin_action_t pin_action;
    logic        output_level_ctrl;
    logic        output_invert;
    logic        duty_period_swap;
    logic        clear_source_select;
  } timer_ctrl1_t;

endpackage

// [hw/match_unit.sv]
module match_unit #(
  parameter int W = 10
) (
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] target,
  output logic              hit
);

  logic [W-1:0] next_count;

  // Match fires one count early so the cleared cycle makes the period exact
  assign next_count = count + {{(W-1){1'b0}}, 1'b1};
  assign hit        = (next_count == target);

endmodule

// [hw/pwm_level.sv]
module pwm_level #(
  parameter int CW = 10,
  parameter int PW = 3
) (
  input  wire logic [CW-1:0] count,
  input  wire logic [CW-1:0] cmp_a,
  input  wire logic [PW-1:0] cmp_p,
  input  wire logic          swap,
  output logic               active
);

  logic [CW:0] p_span;
  logic [CW:0] period;
  logic [CW:0] duty;

  // Zero period value means the full count of the counter
  assign p_span = (cmp_p == '0) ? {1'b1, {CW{1'b0}}} : {1'b0, cmp_p, {(CW-PW){1'b0}}};
  assign period = swap ? {1'b0, cmp_a} : p_span;
  assign duty   = swap ? p_span : {1'b0, cmp_a};
  assign active = (duty >= period) | ({1'b0, count} < duty);

endmodule

// [sim/pin_load.sv]
module pin_load (
  input  wire logic        pclk,
  input  wire logic        clr,
  input  wire logic        pin,
  input  wire logic        oe,
  output logic      [15:0] high_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic level;
  // Pull-down on the load: a released pin reads low
  assign level = oe ? pin : 1'b0;
  always @(negedge pclk) high_cnt <= clr ? 16'h0 : high_cnt + 16'(level);
endmodule

// [sim/std_timer_compare_pwm_checker.sv]
module std_timer_compare_pwm_checker
  import timer_pkg::*;
#(
  parameter int CW = 10,
  parameter int PW = 3
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_output_pin_o,
  input wire logic        timer_output_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c1_q;
  logic       on_q;
  logic [1:0] age_q;
  logic       wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  // Shadows of control; age lets the registered pin settle after a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q  <= 8'h0;
      on_q  <= 1'b0;
      age_q <= 2'h0;
    end else begin
      if (wr && paddr == 12'h004) c1_q <= pwdata[7:0];
      if (wr && paddr == 12'h000) on_q <= pwdata[3];
      if (wr && paddr <= 12'h004) age_q <= 2'h0;
      else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no pready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_err_unmapped: assert property (psel && !penable && paddr > 12'h014 |=> pslverr && prdata == 32'h0)
    else $error("unmapped accepted");
  a_pin_released: assert property (!timer_output_pin_oe |-> !timer_output_pin_o)
    else $error("released pin high");
  a_timer_no_drive: assert property (age_q == 2'h3 && c1_q[7:6] == MODE_TIMER |-> !timer_output_pin_oe)
    else $error("timer mode drives");
  a_out_drive: assert property (
    age_q == 2'h3 && c1_q[7:6] inside {MODE_COMPARE, MODE_PWM} |-> timer_output_pin_oe) else $error("pin not driven");
  a_init_level: assert property (
    wr && paddr == 12'h000 && pwdata[3] && !on_q && c1_q[7:6] == MODE_COMPARE
    |-> ##[1:3] timer_output_pin_o == (c1_q[3] ^ c1_q[2])) else $error("bad initial level");
  a_pwm_forced: assert property (
    age_q == 2'h3 && on_q && c1_q[7:6] == MODE_PWM && !c1_q[5]
    |-> timer_output_pin_o == (c1_q[4] ~^ c1_q[3] ^ c1_q[2])) else $error("bad forced level");
endmodule

// [sim/tb_top.sv]
module tb_top
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_o, pin_oe, clr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [15:0] high_cnt;
  int          num_errors, n_compared, seed;

  std_timer_compare_pwm #(.CW(10), .PW(3)) u_std_timer_compare_pwm (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_output_pin_o(pin_o), .timer_output_pin_oe(pin_oe));
  pin_load u_pin_load (.pclk(pclk), .clr(clr), .pin(pin_o), .oe(pin_oe), .high_cnt(high_cnt));

  task automatic close_out;
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", n, x, g);
      num_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'(pready));
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic poll(input logic [31:0] x);
    int k;
    k = 0;
    do begin
      apb(1'b0, 12'h010, 32'h0);
      k++;
    end while (r !== x && k < 400);
    chk("status", x, r);
    if (r !== x) close_out();
  endtask

  // Outside pin action 0, duty at or beyond the period means the pin never leaves its active level
  function automatic int exp_high(int sw, int a, int p, int act, int win, logic lv);
    int per, dut, n;
    per = sw ? a : (p == 0 ? 1024 : p * 128);
    dut = sw ? (p == 0 ? 1024 : p * 128) : a;
    n = act == 0 ? 0 : (act == 1 || dut >= per) ? win : win / per * dut;
    return lv ? n : win - n;
  endfunction

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    // swap, compare A, period compare, pin action, window
    int          pw [6][5] = '{'{0, 0, 1, 2, 256}, '{0, 200, 1, 2, 256}, '{1, 300, 1, 2, 600},
                               '{1, 100, 0, 2, 200}, '{0, 50, 2, 0, 512}, '{0, 50, 2, 1, 512}};
    logic [31:0] a;
    logic [1:0]  act;
    logic        oc, inv, ccl, dr;
    seed       = 14235;
    num_errors = 0;
    n_compared = 0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h0;
    pwdata     = 32'h0;
    pstrb      = 4'hf;
    clr        = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk("ctrl1 reset", 32'h0, r);
    apb(1'b0, 12'h020, 32'h0);
    chk("pslverr", 32'h1, 32'(e));
    for (int m = 0; m < 5; m++) begin
      a   = $random(seed);
      act = m[1:0];
      oc  = a[0];
      inv = a[1];
      ccl = m[0];
      dr  = m < 4;
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, {24'h00_0000, dr ? MODE_COMPARE : MODE_TIMER, act, oc, inv, 1'b0, ccl});
      apb(1'b1, 12'h008, {26'h0, a[7:2]} + (ccl ? 32'hc8 : 32'h28));
      apb(1'b1, 12'h00C, 32'h1);
      apb(1'b1, 12'h010, 32'h3);
      apb(1'b1, 12'h000, 32'h8);
      repeat (3) @(posedge pclk);
      chk("pin init", 32'(dr & (oc ^ inv)), 32'(pin_o));
      chk("oe", 32'(dr), 32'(pin_oe));
      poll(ccl ? 32'h1 : 32'h3);
      repeat (2) @(posedge pclk);
      chk("pin match", 32'(dr & (inv ^ (act == 2'h1 ? 1'b0 : act == 2'h2 ? 1'b1 : act[0] ^ oc))), 32'(pin_o));
    end
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      if (i == 0) pw[0][1] = 1 + a[6:0] % 127;
      oc  = a[7];
      inv = a[8];
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, {24'h00_0000, MODE_PWM, 2'(pw[i][3]), oc, inv, 1'(pw[i][0]), a[9]});
      apb(1'b1, 12'h008, pw[i][1]);
      apb(1'b1, 12'h00C, pw[i][2]);
      apb(1'b1, 12'h000, 32'h8);
      repeat (700) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (pw[i][4]) @(posedge pclk);
      chk("pwm high", exp_high(pw[i][0], pw[i][1], pw[i][2], pw[i][3], pw[i][4], oc ^ inv), 32'(high_cnt));
    end
    close_out();
  end
endmodule

bind std_timer_compare_pwm std_timer_compare_pwm_checker #(.CW(CW), .PW(PW)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_output_pin_o(timer_output_pin_o), .timer_output_pin_oe(timer_output_pin_oe));
